// [design/tcs_config_two.sv]
// Notes on behaviour
// - Half-rate bit set makes first time-base counter step every two clocks.
// - Half-rate bit clear uses the primary prescale and source fields.
// - Internal reset only while soft reset and stop bits are both set.
// - Unit stays in reset until software writes soft reset back to zero.
// - During soft reset only that bit is writable; primary and status stay readable; host avoids other registers.
// - Two-bit bank field selects one of four entry-table banks, resets 00.
// - Bank field accepts only its first write after reset.
// - Three-bit divider gives channel filter clock of system clock /4 to /512.
// - Divider resets to zero, so filter clock is system clock /4.
// - External clock filter bit picks fixed four-clock or channel filter; write-once.
// - Output-disable bit makes channel fifteen an input tri-stating all outputs when low.
// - Output-disable input reaches output enables without synchroniser.
// - Output-disable bit clear leaves channel fifteen an ordinary channel.
`timescale 1ns/1ps
module tcs_config_two
  import tcs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // AXI4-Lite write address.
  input wire logic [tcs_pkg::TCS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [tcs_pkg::TCS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer pins.
  input wire logic second_base_clock_input,
  input wire logic [tcs_pkg::TCS_CHANNELS-1:0] channel_pin_in,
  input wire logic [tcs_pkg::TCS_CHANNELS-1:0] channel_pin_out_req,
  input wire logic [tcs_pkg::TCS_CHANNELS-1:0] channel_pin_oe_req,
  output logic [tcs_pkg::TCS_CHANNELS-1:0] channel_pin_out,
  output logic [tcs_pkg::TCS_CHANNELS-1:0] channel_pin_oe,
  // Derived timing to the timer core.
  output logic first_base_tick,
  output logic filter_tick,
  output logic second_base_clock_filtered,
  output logic [1:0] entry_table_bank,
  output logic unit_in_reset
);
  // ==========================================================================
  // Configuration state.
  logic half_rate_select;
  logic soft_reset_request;
  logic [2:0] filter_clock_divider;
  logic ext_clock_filter_select;
  logic output_disable_enable;
  logic bank_locked;
  logic ext_filt_locked;
  logic out_dis_locked;
  logic [1:0] first_base_prescale_field;
  logic prescale_source_select;
  logic unit_stop;
  logic [3:0] reset_age;

  logic aw_held;
  logic w_held;
  logic [TCS_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [15:0] secondary_view;
  logic [15:0] primary_view;
  logic [31:0] next_rdata;
  logic next_rerr;

  logic [TCS_PRESCALE_W-1:0] prescale_count;
  logic [TCS_PRESCALE_W-1:0] next_prescale_count;
  logic half_toggle;
  logic t2_meta;
  logic t2_sync;
  logic [8:0] filter_count;

  // Maps a power-of-two exponent to an all-ones terminal count.
  function automatic logic [TCS_PRESCALE_W-1:0] tcs_mask(input logic [3:0] exp2);
    tcs_mask = TCS_PRESCALE_W'((11'h1 << exp2) - 11'h1);
  endfunction

  // ==========================================================================
  // Write channel: address and data taken in either order.
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TCS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr == TCS_OFF_SECONDARY || aw_addr == TCS_OFF_PRIMARY) ?
                     TCS_RESP_OKAY : TCS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Secondary register. While soft reset is held, only that bit is writable.
  logic sec_wr;
  logic sec_lo;
  assign sec_wr = wr_fire && aw_addr == TCS_OFF_SECONDARY;
  assign sec_lo = sec_wr && w_strb[0] && !soft_reset_request;
  logic sec_hi;
  assign sec_hi = sec_wr && w_strb[1] && !soft_reset_request;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      soft_reset_request <= 1'b0;
    end else if (sec_wr && w_strb[0]) begin
      soft_reset_request <= w_data[TCS_SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      half_rate_select <= 1'b0;
    end else if (sec_hi) begin
      half_rate_select <= w_data[TCS_HALF_RATE_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      filter_clock_divider <= TCS_FILT_DIV_RESET;
    end else if (sec_lo) begin
      filter_clock_divider <= w_data[TCS_FILT_DIV_LO +: 3];
    end
  end

  // Write-once fields: each lock sets on its first write, cleared by reset.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      entry_table_bank <= TCS_BANK_RESET;
      bank_locked <= 1'b0;
    end else if (sec_lo && !bank_locked) begin
      entry_table_bank <= w_data[TCS_BANK_LO +: 2];
      bank_locked <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_clock_filter_select <= 1'b0;
      ext_filt_locked <= 1'b0;
    end else if (sec_lo && !ext_filt_locked) begin
      ext_clock_filter_select <= w_data[TCS_EXT_FILT_BIT];
      ext_filt_locked <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      output_disable_enable <= 1'b0;
      out_dis_locked <= 1'b0;
    end else if (sec_lo && !out_dis_locked) begin
      output_disable_enable <= w_data[TCS_OUT_DIS_BIT];
      out_dis_locked <= 1'b1;
    end
  end

  // Local copy of the primary fields this block depends on.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      first_base_prescale_field <= 2'h0;
      prescale_source_select <= 1'b0;
      unit_stop <= 1'b0;
    end else if (wr_fire && aw_addr == TCS_OFF_PRIMARY && w_strb[0] && !soft_reset_request) begin
      first_base_prescale_field <= w_data[TCS_PRE_LO +: 2];
      prescale_source_select <= w_data[TCS_PSRC_BIT];
      unit_stop <= w_data[TCS_STOP_BIT];
    end
  end

  // ==========================================================================
  // Internal reset and its age, so software can see the minimum hold pass.
  assign unit_in_reset = soft_reset_request && unit_stop;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reset_age <= 4'h0;
    end else if (!unit_in_reset) begin
      reset_age <= 4'h0;
    end else if (reset_age != 4'(TCS_RESET_MIN_CYCLES)) begin
      reset_age <= reset_age + 4'h1;
    end
  end

  // ==========================================================================
  // Read channel.
  assign secondary_view = {7'h0, half_rate_select, soft_reset_request, entry_table_bank,
                           filter_clock_divider, ext_clock_filter_select, output_disable_enable};
  assign primary_view = {12'h0, unit_stop, prescale_source_select, first_base_prescale_field};
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_rdata = 32'h0;
    next_rerr = 1'b0;
    case (s_axi_araddr)
      TCS_OFF_SECONDARY: begin
        // Only the soft reset bit is visible while it is set.
        next_rdata = soft_reset_request ? 32'(16'h1 << TCS_SOFT_RESET_BIT) : {16'h0, secondary_view};
      end
      TCS_OFF_PRIMARY: begin
        next_rdata = {16'h0, primary_view};
      end
      TCS_OFF_STATUS: begin
        next_rdata = {26'h0, reset_age == 4'(TCS_RESET_MIN_CYCLES), unit_in_reset, reset_age};
      end
      default: begin
        next_rerr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= TCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? TCS_RESP_SLVERR : TCS_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // First time-base prescaler. Source divides by 32 or 4, field by 1..8.
  logic [TCS_PRESCALE_W-1:0] prescale_limit;
  assign prescale_limit = tcs_mask(4'({1'b0, prescale_source_select ? 3'h2 : 3'h5}) +
                                   4'({2'h0, first_base_prescale_field}));

  always_comb begin
    next_prescale_count = prescale_count + TCS_PRESCALE_W'(1);
    if (prescale_count >= prescale_limit) begin
      next_prescale_count = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_count <= '0;
      half_toggle <= 1'b0;
      first_base_tick <= 1'b0;
    end else if (unit_in_reset) begin
      prescale_count <= '0;
      half_toggle <= 1'b0;
      first_base_tick <= 1'b0;
    end else if (half_rate_select) begin
      prescale_count <= '0;
      half_toggle <= !half_toggle;
      first_base_tick <= half_toggle;
    end else begin
      half_toggle <= 1'b0;
      prescale_count <= next_prescale_count;
      first_base_tick <= prescale_count >= prescale_limit;
    end
  end

  // ==========================================================================
  // Channel filter clock: system clock divided by 4 << divider.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      filter_count <= 9'h0;
      filter_tick <= 1'b0;
    end else begin
      filter_count <= filter_count + 9'h1;
      filter_tick <= (filter_count & 9'(tcs_mask(4'({1'b0, filter_clock_divider}) + 4'h2))) ==
                     9'(tcs_mask(4'({1'b0, filter_clock_divider}) + 4'h2));
    end
  end

  // Second time-base clock pin: two flops, then the selected filter.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      t2_meta <= 1'b0;
      t2_sync <= 1'b0;
    end else begin
      t2_meta <= second_base_clock_input;
      t2_sync <= t2_meta;
    end
  end

  tcs_pin_filter u_t2_filter (
    .mclk(mclk),
    .rst_b(rst_b),
    .sample_tick(filter_tick),
    .use_tick(ext_clock_filter_select),
    .pin_sync(t2_sync),
    .pin_filtered(second_base_clock_filtered)
  );

  // ==========================================================================
  // Pin drivers. The disable path is deliberately unsynchronised so a fault
  // on channel fifteen tri-states outputs even with no clock running.
  logic outputs_disabled;
  assign outputs_disabled = output_disable_enable && !channel_pin_in[TCS_CHANNELS-1];

  always_comb begin
    channel_pin_out = channel_pin_out_req;
    channel_pin_oe = outputs_disabled ? '0 : channel_pin_oe_req;
    if (output_disable_enable) begin
      channel_pin_oe[TCS_CHANNELS-1] = 1'b0;
    end
    // With the bit clear, channel fifteen passes through unchanged.
  end
endmodule // tcs_config_two

// [design/tcs_pin_filter.sv]
`timescale 1ns/1ps
module tcs_pin_filter
  import tcs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Sampling control.
  input wire logic sample_tick,
  input wire logic use_tick,
  // Signal.
  input wire logic pin_sync,
  output logic pin_filtered
);
  // ==========================================================================
  // A new level must be seen on four consecutive samples before it is passed.
  logic [2:0] agree_count;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      agree_count <= 3'h0;
      pin_filtered <= 1'b0;
    end else if (pin_sync == pin_filtered) begin
      agree_count <= 3'h0;
    end else if (!use_tick || sample_tick) begin
      if (agree_count == 3'(TCS_FIXED_FILTER_CYCLES - 1)) begin
        pin_filtered <= pin_sync;
        agree_count <= 3'h0;
      end else begin
        agree_count <= agree_count + 3'h1;
      end
    end
  end
endmodule // tcs_pin_filter

// [design/tcs_pkg.sv]
package tcs_pkg;
  // ==========================================================================
  // Register map (byte addresses on the AXI4-Lite port).
  localparam logic [7:0] TCS_OFF_SECONDARY = 8'h00;
  localparam logic [7:0] TCS_OFF_PRIMARY = 8'h04;
  localparam logic [7:0] TCS_OFF_STATUS = 8'h08;
  localparam int TCS_ADDR_W = 8;

  // ==========================================================================
  // Secondary configuration fields (bit 0 is the most significant in the
  // numbering of the field table, so bit n maps to data bit 15-n).
  localparam int TCS_HALF_RATE_BIT = 8;
  localparam int TCS_SOFT_RESET_BIT = 7;
  localparam int TCS_BANK_LO = 5;
  localparam int TCS_FILT_DIV_LO = 2;
  localparam int TCS_EXT_FILT_BIT = 1;
  localparam int TCS_OUT_DIS_BIT = 0;
  localparam logic [1:0] TCS_BANK_RESET = 2'h0;
  localparam logic [2:0] TCS_FILT_DIV_RESET = 3'h0;

  // Primary configuration fields held locally.
  localparam int TCS_PRE_LO = 0;
  localparam int TCS_PSRC_BIT = 2;
  localparam int TCS_STOP_BIT = 3;

  // ==========================================================================
  // Timing.
  localparam int TCS_FIXED_FILTER_CYCLES = 4;
  localparam int TCS_RESET_MIN_CYCLES = 9;
  localparam int TCS_PRESCALE_W = 10;
  localparam int TCS_CHANNELS = 16;

  // AXI responses.
  localparam logic [1:0] TCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] TCS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TCS_FILT_IDLE = 2'b00,
    TCS_FILT_COUNT = 2'b01
  } tcs_filt_state_t;
endpackage

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  import tcs_pkg::*;
  logic mclk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, second_base_clock_input;
  logic first_base_tick, filter_tick, second_base_clock_filtered, unit_in_reset;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, entry_table_bank;
  logic [15:0] channel_pin_in, channel_pin_out_req, channel_pin_oe_req, channel_pin_out, channel_pin_oe;
  int num_errors, n_checks, cycles;

  tcs_config_two i_tcs_config_two (.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .second_base_clock_input, .channel_pin_in, .channel_pin_out_req, .channel_pin_oe_req, .channel_pin_out,
    .channel_pin_oe, .first_base_tick, .filter_tick, .second_base_clock_filtered, .entry_table_bank,
    .unit_in_reset);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ==========================================================================
  // Helpers.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // The longest wait is three 512-clock filter periods, so this ceiling is generous.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
  endtask

  // Handshakes are sampled half a cycle early so the design's own edge updates cannot race them.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    logic [1:0] br;
    bh = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bh) begin
      @(negedge mclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge mclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(32'(br), 32'(er));
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    rh = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rh) begin
      @(negedge mclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(d, exp);
    chk(32'(r), 32'(TCS_RESP_OKAY));
  endtask

  // The first interval after a rate change may be partial, so the one between the second and third ticks is measured.
  task automatic meas(input logic sel, input int exp);
    int n;
    n = 0;
    repeat (2) begin
      @(negedge mclk);
      while ((sel ? first_base_tick : filter_tick) !== 1'b1) @(negedge mclk);
    end
    do begin
      @(negedge mclk);
      n++;
    end while ((sel ? first_base_tick : filter_tick) !== 1'b1);
    chk(32'(n), 32'(exp));
  endtask

  task automatic pin2(input logic lvl, input int n);
    second_base_clock_input <= lvl;
    repeat (n) @(posedge mclk);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_bank();
    for (int b = 0; b < 4; b++) begin
      do_reset();
      rchk(TCS_OFF_SECONDARY, 32'h0);
      wr(TCS_OFF_SECONDARY, 16'(b << 5), TCS_RESP_OKAY);
      chk(32'(entry_table_bank), 32'(b));
    end
    wr(TCS_OFF_SECONDARY, 16'h0001, TCS_RESP_OKAY);
    rchk(TCS_OFF_SECONDARY, 32'h60);
    channel_pin_in <= 16'h0;
    @(negedge mclk);
    chk(32'(channel_pin_oe), 32'h5a5a);
    chk(32'(channel_pin_out), 32'h3c3c);
    $display("bank done");
  endtask

  task automatic t_disable();
    do_reset();
    wr(TCS_OFF_SECONDARY, 16'hfe01, TCS_RESP_OKAY);
    rchk(TCS_OFF_SECONDARY, 32'h1);
    channel_pin_in <= 16'hffff;
    @(negedge mclk);
    chk(32'(channel_pin_oe), 32'h5a5a);
    @(posedge mclk);
    channel_pin_in <= 16'h7fff;
    @(negedge mclk);
    chk(32'(channel_pin_oe), 32'h0);
    wr(TCS_OFF_SECONDARY, 16'h0000, TCS_RESP_OKAY);
    chk(32'(channel_pin_oe), 32'h0);
    wr(8'h0c, 16'h0, TCS_RESP_SLVERR);
    $display("disable done");
  endtask

  task automatic t_rates();
    do_reset();
    wr(TCS_OFF_PRIMARY, 16'h0004, TCS_RESP_OKAY);
    meas(1'b1, 4);
    wr(TCS_OFF_PRIMARY, 16'h0003, TCS_RESP_OKAY);
    meas(1'b1, 256);
    for (int d = 0; d < 8; d++) begin
      wr(TCS_OFF_SECONDARY, 16'(16'h0100 | (d << 2)), TCS_RESP_OKAY);
      meas(1'b0, 4 << d);
    end
    meas(1'b1, 2);
    $display("rates done");
  endtask

  task automatic t_soft();
    do_reset();
    wr(TCS_OFF_SECONDARY, 16'h0080, TCS_RESP_OKAY);
    chk(32'(unit_in_reset), 32'h0);
    wr(TCS_OFF_SECONDARY, 16'h0000, TCS_RESP_OKAY);
    wr(TCS_OFF_PRIMARY, 16'h0008, TCS_RESP_OKAY);
    wr(TCS_OFF_SECONDARY, 16'h0180, TCS_RESP_OKAY);
    chk(32'(unit_in_reset), 32'h1);
    wr(TCS_OFF_PRIMARY, 16'h0000, TCS_RESP_OKAY);
    rchk(TCS_OFF_SECONDARY, 32'h80);
    repeat (9) @(posedge mclk);
    chk(32'(unit_in_reset), 32'h1);
    wr(TCS_OFF_SECONDARY, 16'h0000, TCS_RESP_OKAY);
    chk(32'(unit_in_reset), 32'h0);
    rchk(TCS_OFF_PRIMARY, 32'h8);
    $display("soft reset done");
  endtask

  task automatic t_ext_filter();
    do_reset();
    pin2(1'b1, 2);
    pin2(1'b0, 40);
    chk(32'(second_base_clock_filtered), 32'h0);
    pin2(1'b1, 12);
    chk(32'(second_base_clock_filtered), 32'h1);
    pin2(1'b0, 1);
    do_reset();
    wr(TCS_OFF_SECONDARY, 16'h0002, TCS_RESP_OKAY);
    pin2(1'b0, 40);
    pin2(1'b1, 8);
    pin2(1'b0, 40);
    chk(32'(second_base_clock_filtered), 32'h0);
    pin2(1'b1, 40);
    chk(32'(second_base_clock_filtered), 32'h1);
    $display("ext filter done");
  endtask

  initial begin
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h3;
    second_base_clock_input = 1'b0;
    channel_pin_in = 16'hffff;
    channel_pin_out_req = 16'h3c3c;
    channel_pin_oe_req = 16'h5a5a;
    cycles = 0;
    num_errors = 0;
    n_checks = 0;
    @(posedge mclk);
    t_bank();
    t_disable();
    t_rates();
    t_soft();
    t_ext_filter();
    end_of_test();
  end
endmodule // tb

// [verif/tcs_config_two_props.sv]
`timescale 1ns/1ps
module tcs_config_two_props
  import tcs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Bus handshakes.
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Pins and timing.
  input wire logic [tcs_pkg::TCS_CHANNELS-1:0] channel_pin_in,
  input wire logic [tcs_pkg::TCS_CHANNELS-1:0] channel_pin_out_req,
  input wire logic [tcs_pkg::TCS_CHANNELS-1:0] channel_pin_oe_req,
  input wire logic [tcs_pkg::TCS_CHANNELS-1:0] channel_pin_out,
  input wire logic [tcs_pkg::TCS_CHANNELS-1:0] channel_pin_oe,
  input wire logic first_base_tick,
  input wire logic filter_tick,
  input wire logic [1:0] entry_table_bank,
  input wire logic unit_in_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Gap since the last filter tick; the slowest divide is 512.
  logic [9:0] filt_gap;
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b) filt_gap <= 10'h0;
    else if (filter_tick) filt_gap <= 10'h0;
    else filt_gap <= filt_gap + 10'h1;
  // ==========================================================================
  // Assertions.
  a_oe_gating: assert property ((channel_pin_oe == channel_pin_oe_req) ||
    (channel_pin_oe == {1'b0, channel_pin_oe_req[14:0]}) || (!channel_pin_in[15] && channel_pin_oe == 16'h0))
    else $error("output enable gating wrong");
  a_out_pass: assert property (channel_pin_out == channel_pin_out_req)
    else $error("pin output not passed");
  a_base_gap: assert property (first_base_tick |=> !first_base_tick)
    else $error("base ticks too close");
  a_filt_min: assert property (filter_tick |=> !filter_tick [*3])
    else $error("filter ticks too close");
  a_filt_max: assert property (filt_gap < 10'h200)
    else $error("filter tick missing");
  a_reset_cause: assert property ($changed(unit_in_reset) |-> $rose(s_axi_bvalid))
    else $error("internal reset moved without a write");
  a_bank_cause: assert property ($changed(entry_table_bank) |-> $rose(s_axi_bvalid))
    else $error("bank moved without a write");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  c_in_reset: cover property ($rose(unit_in_reset));
  c_all_off: cover property (channel_pin_oe == 16'h0 && channel_pin_oe_req != 16'h0);
  c_fast_filt: cover property (filter_tick ##4 filter_tick);
endmodule // tcs_config_two_props

bind tcs_config_two tcs_config_two_props i_tcs_config_two_props (.mclk, .rst_b, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .channel_pin_in, .channel_pin_out_req,
  .channel_pin_oe_req, .channel_pin_out, .channel_pin_oe, .first_base_tick, .filter_tick, .entry_table_bank,
  .unit_in_reset);
